// ---- core/crcacc_pkg.sv ----
// package: register map, reset values and types of the crc16 byte accumulator
// Function
// - fixed polynomial x16+x15+x2+1 only
// - bytes in, sixteen-bit remainder out
// - each input write with lane 0 strobed folds byte into remainder
// - update finishes within one cycle
// - low result byte readable, writable, resets ones
// - high result byte readable, writable, resets ones
// - input register write-only, at most one update per write
package crcacc_pkg;
	// printed offsets are not multiples of four: they are indices
	localparam logic [11:0] CRCACC_IDX_RES_LO = 12'h18e;
	localparam logic [11:0] CRCACC_IDX_RES_HI = 12'h18f;
	localparam logic [11:0] CRCACC_IDX_BYTE_IN = 12'h190;
	localparam int CRCACC_ADDR_W = 14;
	localparam logic [7:0] CRCACC_RES_LO_RST = 8'hff;
	localparam logic [7:0] CRCACC_RES_HI_RST = 8'hff;
	// reflected form of x16+x15+x2+1
	localparam logic [15:0] CRCACC_POLY_REFL = 16'ha001;
	localparam logic [1:0] CRCACC_RESP_OKAY = 2'h0;
	localparam logic [1:0] CRCACC_RESP_SLVERR = 2'h2;

	// one byte request to the crc core
	typedef struct packed {
		logic load_lo;
		logic load_hi;
		logic fold;
		logic [7:0] data;
	} crcacc_req_t;

	// byte address of a register index
	function automatic logic [CRCACC_ADDR_W-1:0] crcacc_byte_addr(
			input logic [11:0] idx);
		crcacc_byte_addr = {idx, 2'b00};
	endfunction
endpackage

// ---- core/crcacc_core.sv ----
// crc16 remainder register with byte fold and seed loads
`timescale 1ns/1ps
`default_nettype none
module crcacc_core
	import crcacc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// request
	input wire crcacc_req_t req,
	// remainder
	output logic [15:0] crc_ff
);
	logic [15:0] nxt_crc;

	// fold one byte lsb first, eight shifts in one cycle
	function automatic logic [15:0] crcacc_fold(input logic [15:0] c,
			input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRCACC_POLY_REFL) : (r >> 1);
		end
		crcacc_fold = r;
	endfunction

	// next remainder: fold wins, else byte seeds
	always_comb begin
		nxt_crc = crc_ff;
		if (req.fold) begin
			nxt_crc = crcacc_fold(crc_ff, req.data);
		end else begin
			if (req.load_lo) begin
				nxt_crc[7:0] = req.data;
			end
			if (req.load_hi) begin
				nxt_crc[15:8] = req.data;
			end
		end
	end

	// remainder register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			crc_ff <= {CRCACC_RES_HI_RST, CRCACC_RES_LO_RST};
		end else begin
			crc_ff <= nxt_crc;
		end
	end
endmodule
`default_nettype wire

// ---- core/crcacc_top.sv ----
// crc16 byte accumulator with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module crcacc_top
	import crcacc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// write address
	input wire logic [CRCACC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address
	input wire logic [CRCACC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// write side state
	logic aw_have_ff;
	logic w_have_ff;
	logic [CRCACC_ADDR_W-1:0] aw_addr_ff;
	logic [7:0] w_byte_ff;
	logic w_lane0_ff;
	logic do_write;
	// handshake strobes
	logic aw_take;
	logic w_take;
	logic rd_take;
	// next values of the response and read registers
	logic [1:0] nxt_bresp;
	logic [31:0] nxt_rdata;
	logic [1:0] nxt_rresp;
	// core request and remainder
	crcacc_req_t req;
	logic [15:0] crc;

	// true when a byte address falls on the word of a register index;
	// the two low address bits are ignored, so any byte lane hits
	function automatic logic reg_hit(input logic [CRCACC_ADDR_W-1:0] a,
			input logic [11:0] idx);
		logic [CRCACC_ADDR_W-1:0] base;
		base = crcacc_byte_addr(idx);
		reg_hit = (a[CRCACC_ADDR_W-1:2] == base[CRCACC_ADDR_W-1:2]);
	endfunction

	// register offset hit test for the write response
	function automatic logic is_mapped(input logic [CRCACC_ADDR_W-1:0] a);
		is_mapped = reg_hit(a, CRCACC_IDX_RES_LO)
			|| reg_hit(a, CRCACC_IDX_RES_HI)
			|| reg_hit(a, CRCACC_IDX_BYTE_IN);
	endfunction

	// handshakes: a channel moves when valid and ready meet at an edge
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign rd_take = s_axi_arvalid && s_axi_arready;

	// a write executes once both halves are held and the last answer is
	// gone; holding it off keeps exactly one response per write
	assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;

	// address and data are captured independently, in either order
	always_ff @(posedge clk) begin
		if (!rstn) begin
			aw_have_ff <= 1'b0;
			aw_addr_ff <= '0;
		end else if (aw_take) begin
			aw_have_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr;
		end else if (do_write) begin
			aw_have_ff <= 1'b0;
		end
	end

	// write data capture; only lane 0 carries a register byte
	always_ff @(posedge clk) begin
		if (!rstn) begin
			w_have_ff <= 1'b0;
			w_byte_ff <= '0;
			w_lane0_ff <= 1'b0;
		end else if (w_take) begin
			w_have_ff <= 1'b1;
			w_byte_ff <= s_axi_wdata[7:0];
			w_lane0_ff <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_have_ff <= 1'b0;
		end
	end

	// ready raised one cycle after reset, dropped while holding a beat
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !(aw_have_ff || aw_take) || do_write;
			s_axi_wready <= !(w_have_ff || w_take) || do_write;
		end
	end

	// decode the write into a core request;
	// a mapped write with lane 0 off is answered okay but changes nothing
	always_comb begin
		req = '0;
		req.data = w_byte_ff;
		if (do_write && w_lane0_ff) begin
			if (reg_hit(aw_addr_ff, CRCACC_IDX_RES_LO)) begin
				req.load_lo = 1'b1;
			end else if (reg_hit(aw_addr_ff, CRCACC_IDX_RES_HI)) begin
				req.load_hi = 1'b1;
			end else if (reg_hit(aw_addr_ff, CRCACC_IDX_BYTE_IN)) begin
				req.fold = 1'b1;
			end
		end
	end

	// response code picked when the write executes; unmapped gets slverr
	always_comb begin
		nxt_bresp = s_axi_bresp;
		if (do_write) begin
			if (is_mapped(aw_addr_ff)) begin
				nxt_bresp = CRCACC_RESP_OKAY;
			end else begin
				nxt_bresp = CRCACC_RESP_SLVERR;
			end
		end
	end

	// write response valid: raised on execute, held until bready
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// write response code; changes only on execute, so it stands with bvalid
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_bresp <= CRCACC_RESP_OKAY;
		end else begin
			s_axi_bresp <= nxt_bresp;
		end
	end

	// read address ready; low while a read answer waits, so one at a time
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_take;
		end
	end

	// read data mux; the input register reads as zero
	always_comb begin
		nxt_rdata = 32'h00000000;
		nxt_rresp = CRCACC_RESP_OKAY;
		if (reg_hit(s_axi_araddr, CRCACC_IDX_RES_LO)) begin
			nxt_rdata = {24'h000000, crc[7:0]};
		end else if (reg_hit(s_axi_araddr, CRCACC_IDX_RES_HI)) begin
			nxt_rdata = {24'h000000, crc[15:8]};
		end else if (reg_hit(s_axi_araddr, CRCACC_IDX_BYTE_IN)) begin
			nxt_rdata = 32'h00000000;
		end else begin
			nxt_rresp = CRCACC_RESP_SLVERR;
		end
	end

	// read valid: raised one cycle after the take, held until rready
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// read data and code load only on a take, so they stand until rready
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= CRCACC_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rdata <= nxt_rdata;
			s_axi_rresp <= nxt_rresp;
		end
	end

	// remainder store and byte fold; the core updates on the edge the
	// write executes, so a read issued after bvalid sees the new remainder
	crcacc_core u_core (
		.clk(clk),
		.rstn(rstn),
		.req(req),
		.crc_ff(crc)
	);
endmodule
`default_nettype wire

// ---- testbench/crcacc_monitor.sv ----
// assertion checker for the crc16 accumulator register slave
`timescale 1ns/1ps
`default_nettype none
module crcacc_monitor
	import crcacc_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [CRCACC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_wresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer lost");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer lost");
	a_rdata_byte: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("wide data");
	a_input_wo: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr[13:2] ==
		CRCACC_IDX_BYTE_IN |=> s_axi_rdata == 32'h0) else $error("input read");
	a_write_lat: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write late");
	a_read_lat: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
	a_one_write: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready && !s_axi_wready) else $error("second beat open");
	a_one_read: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
endmodule
`default_nettype wire

// ---- testbench/crcacc_top_tb.sv ----
// self-checking bench for the crc16 byte accumulator
`timescale 1ns/1ps
`default_nettype none
module crcacc_top_tb
	import crcacc_pkg::*;
;
	logic clk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int fails = 0, samples_checked = 0, cyc = 0;
	logic [15:0] m;
	logic late = 0;
	localparam logic [13:0] LO = {CRCACC_IDX_RES_LO, 2'b00};
	localparam logic [13:0] HI = {CRCACC_IDX_RES_HI, 2'b00};
	localparam logic [13:0] IN = {CRCACC_IDX_BYTE_IN, 2'b00};
	crcacc_top DUT (
		.clk(clk),
		.rstn(rstn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);
	initial forever #12.5 clk = ~clk;
	// reference fold, lsb first
	function automatic logic [15:0] f(logic [15:0] c, logic [7:0] b);
		c ^= {8'h00, b};
		for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		return c;
	endfunction
	task chk(logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask
	// write with address and data offered together
	task wr(logic [13:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= !late;
		do @(posedge clk) begin
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		// a late master raises bready only once the answer is seen
		if (late) begin
			s_axi_bready <= 1;
			@(posedge clk);
		end
		s_axi_bready <= 0;
		chk(s_axi_bresp, r);
	endtask
	task rd(logic [13:0] a, logic [31:0] e);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= !late;
		do @(posedge clk) if (s_axi_arready) s_axi_arvalid <= 0;
		while (!s_axi_rvalid);
		if (late) begin
			s_axi_rready <= 1;
			@(posedge clk);
		end
		s_axi_rready <= 0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, CRCACC_RESP_OKAY);
	endtask
	// read back both result bytes against the model
	task rm;
		rd(LO, m[7:0]);
		rd(HI, m[15:8]);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			test_done;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		repeat (2) @(posedge clk);
		m = 16'hffff;
		rm;
		for (int i = 0; i < 9; i++) wr(IN, 32'h31 + i, 4'h1, 0);
		rd(LO, 32'h37);
		rd(HI, 32'h4b);
		late = 1;
		wr(HI, 32'h12, 4'h1, 0);
		wr(LO, 32'h34, 4'h1, 0);
		wr(IN, 32'h5a, 4'h0, 0);
		m = 16'h1234;
		rm;
		late = 0;
		wr(IN, 32'h01, 4'h1, 0);
		m = f(m, 8'h01);
		rm;
		rd(IN, 32'h0);
		wr(14'h0, 32'h9, 4'h1, CRCACC_RESP_SLVERR);
		rm;
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		repeat (2) @(posedge clk);
		wr(IN, 32'h01, 4'h1, 0);
		rd(LO, 32'h7e);
		rd(HI, 32'h80);
		test_done;
	end
endmodule
bind crcacc_top crcacc_monitor u_mon (
	.clk(clk),
	.rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);
`default_nettype wire
